//--- core/ara_pkg.sv
`default_nettype none
package ara_pkg;
  // Sample, result, accumulator, field and counter widths
  localparam int unsigned SAMPLE_W      = 12;
  localparam int unsigned RESULT_W      = 16;
  localparam int unsigned ACC_W         = 22;
  localparam int unsigned CODE_W        = 4;
  localparam int unsigned ADJ_W         = 3;
  localparam int unsigned CNT_W         = 11;
  // Sample-count codes
  localparam logic [3:0] CODE_MAX       = 4'ha;
  localparam logic [3:0] CODE_NO_SHIFT  = 4'h4;
  // Resolution selection value needed for multi-sample sums
  localparam logic [1:0] RES_SEL_ACCUM  = 2'h1;
  // Reset values
  localparam logic [3:0] CODE_RST       = 4'h0;
  localparam logic [2:0] ADJ_RST        = 3'h0;

  typedef struct packed {
    logic [CODE_W-1:0] sample_count_code;
    logic [ADJ_W-1:0]  result_adjust_shift;
  } ara_cfg_t;

  typedef struct packed {
    logic                result_ready_flag;
    logic                overrun;
    logic [RESULT_W-1:0] result;
  } ara_stat_t;
endpackage
`default_nettype wire

//--- core/ara_accum.sv
`default_nettype none
module ara_accum
  import ara_pkg::*;
#(
  parameter int unsigned ACC_BITS = ACC_W
)(
  input  wire logic                clk_sys,      // 40 MHz clock
  input  wire logic                rst,          // Async reset, high
  input  wire logic                sample_valid, // Raw conversion done
  input  wire logic [SAMPLE_W-1:0] sample_data,  // Raw 12-bit result
  input  wire ara_cfg_t            averaging_control, // Count and adjust
  input  wire logic [1:0]          conversion_resolution_select, // Res
  input  wire logic                result_read,  // Software read strobe
  output var ara_stat_t            status,       // Flags and result
  output logic                     busy          // Partial sum pending
);

  // ==========================================================
  // Sequence control
  logic [ACC_BITS-1:0] acc;
  logic [CNT_W-1:0]    cnt;
  logic [CNT_W-1:0]    target;
  logic [CODE_W-1:0]   code;
  logic                last;
  logic [ACC_BITS-1:0] sum;
  logic [3:0]          auto_sh;
  logic [ACC_BITS-1:0] shifted;
  logic                done;
  logic [RESULT_W-1:0] result;
  logic                result_ready_flag;
  logic                overrun;

  // Reserved codes fold to one sample so they never hang the sequence
  assign code   = (averaging_control.sample_count_code > CODE_MAX)
                  ? CODE_RST : averaging_control.sample_count_code;
  assign target = CNT_W'(1) << code;
  assign last   = (cnt + CNT_W'(1)) >= target;
  assign sum    = acc + ACC_BITS'(sample_data);
  assign done   = sample_valid && last;
  assign busy   = (cnt != '0);
  assign status = '{result_ready_flag: result_ready_flag,
                    overrun:           overrun,
                    result:            result};

  always_comb
  begin
    if (code > CODE_NO_SHIFT)
      auto_sh = code - CODE_NO_SHIFT;
    else
      auto_sh = 4'h0;
  end

  // Reserved codes divide by nothing, whatever the adjust field says
  assign shifted = (averaging_control.sample_count_code > CODE_MAX)
                   ? sum
                   : (sum >> auto_sh)
                     >> averaging_control.result_adjust_shift;

  // ==========================================================
  // Accumulator and counter
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      acc <= '0;
      cnt <= '0;
    end
    else if (sample_valid)
    begin
      if (last)
      begin
        acc <= '0;
        cnt <= '0;
      end
      else
      begin
        acc <= sum;
        cnt <= cnt + CNT_W'(1);
      end
    end
  end

  // ==========================================================
  // Result register and flags
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      result <= '0;
    else if (done)
      result <= shifted[RESULT_W-1:0];
  end

  // Ready set wins over a read in the same cycle; a read blocks an overrun set
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      result_ready_flag <= 1'b0;
      overrun           <= 1'b0;
    end
    else
    begin
      if (done)
        result_ready_flag <= 1'b1;
      else if (result_read)
        result_ready_flag <= 1'b0;
      if (done && result_ready_flag && !result_read)
        overrun <= 1'b1;
      else if (result_read)
        overrun <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  logic [CNT_W:0] gap;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      gap <= '0;
    else if (done)
      gap <= '0;
    else if (sample_valid && gap <= {1'b0, target})
      gap <= gap + (CNT_W+1)'(1);
  end

  property p_ready_on_done;
    @(posedge clk_sys) disable iff (rst)
      done |=> status.result_ready_flag;
  endproperty
  a_ready_on_done: assert property (p_ready_on_done)
    else $error("ready flag not set after full sum");

  property p_ready_needs_done;
    @(posedge clk_sys) disable iff (rst)
      $rose(status.result_ready_flag) |-> $past(done);
  endproperty
  a_ready_needs_done: assert property (p_ready_needs_done)
    else $error("ready flag rose without completed sum");

  property p_n_samples;
    @(posedge clk_sys) disable iff (rst)
      done |-> (gap + (CNT_W+1)'(1) == {1'b0, target});
  endproperty
  a_n_samples: assert property (p_n_samples)
    else $error("output not after exactly N samples");

  property p_clear;
    @(posedge clk_sys) disable iff (rst)
      done |=> (acc == '0 && cnt == '0);
  endproperty
  a_clear: assert property (p_clear)
    else $error("partial sum carried over");

  property p_overrun;
    @(posedge clk_sys) disable iff (rst)
      (done && status.result_ready_flag && !result_read)
        |=> status.overrun;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged");

  property p_overwrite;
    @(posedge clk_sys) disable iff (rst)
      done |=> status.result == $past(shifted[RESULT_W-1:0]);
  endproperty
  a_overwrite: assert property (p_overwrite)
    else $error("result not overwritten");

  property p_single;
    @(posedge clk_sys) disable iff (rst)
      (sample_valid && code == CODE_RST
       && averaging_control.result_adjust_shift == ADJ_RST)
        |=> status.result == RESULT_W'($past(sample_data));
  endproperty
  a_single: assert property (p_single)
    else $error("single sample not passed through");

  property p_no_shift;
    @(posedge clk_sys) disable iff (rst)
      (done && code <= CODE_NO_SHIFT
       && averaging_control.result_adjust_shift == ADJ_RST)
        |=> status.result == RESULT_W'($past(sum));
  endproperty
  a_no_shift: assert property (p_no_shift)
    else $error("shift applied at sixteen or fewer");

  property p_auto_shift;
    @(posedge clk_sys) disable iff (rst)
      (done && code > CODE_NO_SHIFT
       && averaging_control.result_adjust_shift == ADJ_RST)
        |=> status.result
            == RESULT_W'($past(sum) >> ($past(code) - CODE_NO_SHIFT));
  endproperty
  a_auto_shift: assert property (p_auto_shift)
    else $error("automatic shift wrong");

  property p_fits;
    @(posedge clk_sys) disable iff (rst)
      (done && averaging_control.sample_count_code <= CODE_MAX)
        |-> (sum >> auto_sh) < (ACC_BITS'(1) << RESULT_W);
  endproperty
  a_fits: assert property (p_fits)
    else $error("shifted sum exceeds result width");

  c_done: cover property (@(posedge clk_sys) done);
  c_overrun: cover property (@(posedge clk_sys) $rose(status.overrun));
  c_max: cover property (@(posedge clk_sys) done && code == CODE_MAX);
  // Resolution select is not enforced; this shows the legal setup ran
  c_avg_res: cover property (@(posedge clk_sys)
    done && code != CODE_RST
    && conversion_resolution_select == RES_SEL_ACCUM);

endmodule
`default_nettype wire

//--- verification/ara_conv_model.sv
`default_nettype none
// ==========================================
// Conversion core stand-in
module ara_conv_model
  import ara_pkg::*;
(
  input  wire logic                clk_sys,      // Sample clock
  output logic                     sample_valid, // Conversion done
  output logic [SAMPLE_W-1:0]      sample_data   // Raw result
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    sample_valid = 1'b0;
    sample_data  = 12'h000;
  end
  // Idle data is inverted so a stale sample cannot pass for a fresh one
  task automatic send(input int n, input logic [SAMPLE_W-1:0] v);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_sys);
      #1;
      sample_valid = 1'b1;
      sample_data  = v;
    end
    @(posedge clk_sys);
    #1;
    sample_valid = 1'b0;
    sample_data  = ~v;
  endtask
endmodule
`default_nettype wire

//--- verification/ara_accum_bench.sv
`default_nettype none
module ara_accum_bench
  import ara_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk_sys;
  logic                rst;
  logic                sample_valid;
  logic                result_read;
  logic                busy;
  logic [SAMPLE_W-1:0] sample_data;
  logic [1:0]          res_sel;
  ara_cfg_t            cfg;
  ara_stat_t           status;
  int                  err_total;
  int                  checks;
  int                  cycles;
  ara_conv_model ara_conv_model_i (.clk_sys(clk_sys),
    .sample_valid(sample_valid), .sample_data(sample_data));
  ara_accum ara_accum_i (.clk_sys(clk_sys), .rst(rst),
    .sample_valid(sample_valid), .sample_data(sample_data),
    .averaging_control(cfg), .conversion_resolution_select(res_sel),
    .result_read(result_read), .status(status), .busy(busy));
  // ==========================================
  // Helpers
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic wrap_up;
    if (err_total == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      err_total++;
      wrap_up;
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [15:0] exp_res(input logic [3:0] c,
    input logic [2:0] a, input logic [11:0] v);
    logic [31:0] s;
    if (c > CODE_MAX) return {4'h0, v};
    s = (32'h1 << c) * v;
    if (c > CODE_NO_SHIFT) s = s >> (c - CODE_NO_SHIFT);
    return 16'(s >> a);
  endfunction
  task automatic rd;
    @(posedge clk_sys);
    #1;
    result_read = 1'b1;
    @(posedge clk_sys);
    #1;
    result_read = 1'b0;
    chk("ready_rd", status.result_ready_flag, 1'b0);
    chk("ovr_rd", status.overrun, 1'b0);
  endtask
  // Last sample held back a cycle to look at the partial state
  task automatic run(input logic [3:0] c, input logic [2:0] a,
    input logic [11:0] v);
    int n;
    n = (c > CODE_MAX) ? 1 : (1 << c);
    cfg.sample_count_code   = c;
    cfg.result_adjust_shift = a;
    if (n > 1)
    begin
      ara_conv_model_i.send(n - 1, v);
      chk("ready_early", status.result_ready_flag, 1'b0);
      chk("busy", busy, 1'b1);
    end
    ara_conv_model_i.send(1, v);
    chk("result", status.result,
        exp_res(c, a, v));
    chk("ready", status.result_ready_flag, 1'b1);
    rd;
  endtask
  // ==========================================
  // Tests
  initial
  begin
    rst         = 1'b1;
    result_read = 1'b0;
    cfg         = '0;
    res_sel     = RES_SEL_ACCUM;
    repeat (20) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    chk("rst_result", status.result, 16'h0000);
    for (int p = 0; p < 2; p++)
      for (int c = 0; c < 16; c++)
        run(4'(c), p ? ((c > 4) ? 3'h4 : 3'(c)) : 3'h0,
          p ? 12'h9c5 : 12'hfff);
    cfg = '0;
    ara_conv_model_i.send(1, 12'h123);
    ara_conv_model_i.send(1, 12'h456);
    chk("overrun", status.overrun, 1'b1);
    chk("ovr_result", status.result, 16'h0456);
    rd;
    // Reset in mid-sequence must drop the partial sum
    cfg.sample_count_code = 4'h2;
    ara_conv_model_i.send(2, 12'h111);
    chk("busy_mid", busy, 1'b1);
    rst = 1'b1;
    @(posedge clk_sys);
    #1;
    rst = 1'b0;
    chk("busy_rst", busy, 1'b0);
    chk("result_rst", status.result, 16'h0000);
    ara_conv_model_i.send(4, 12'h111);
    chk("after_rst", status.result, exp_res(4'h2, 3'h0, 12'h111));
    chk("ready_rst", status.result_ready_flag, 1'b1);
    rd;
    wrap_up;
  end
endmodule
`default_nettype wire
